/* File: src/chain_link_pkg.sv */
// shared constants and types of the daisy-chain sensor serial interface
`default_nettype none
package chain_link_pkg;
  // clock and link timing
  localparam int CLK_FREQ_HZ     = 50_000_000;
  localparam int TIMEOUT_TIME_MS = 28;
  localparam int TIMEOUT_CYCLES  = TIMEOUT_TIME_MS * (CLK_FREQ_HZ / 1000);
  localparam int TIMEOUT_W       = 21;
  localparam int PERIOD_W        = 16;
  localparam int MEAS_W          = 20;
  localparam int CAL_FALL_EDGES  = 4;

  // word layout on the wire and depth of the transmit fifo
  localparam int WORD_BITS   = 8;
  localparam int FRAME_BITS  = 10;
  localparam int FIFO_DEPTH  = 16;
  localparam int ID_W        = 4;

  // fixed words and command patterns
  localparam logic [7:0] CAL_WORD       = 8'h55;
  localparam logic [7:0] INIT_CMD       = 8'h8C;
  localparam logic [3:0] ASSIGN_PREFIX  = 4'h9;
  localparam logic [4:0] GLOBAL_RW_PREF = 5'h1E;

  // register pointer codes
  localparam logic [1:0] PTR_TEMP   = 2'h0;
  localparam logic [1:0] PTR_CONFIG = 2'h1;
  localparam logic [1:0] PTR_TLOW   = 2'h2;
  localparam logic [1:0] PTR_THIGH  = 2'h3;

  // reset values of the stored registers
  localparam logic [7:0] CONFIG_RESET = 8'h02;
  localparam logic [7:0] TLOW_RESET   = 8'h00;
  localparam logic [7:0] THIGH_RESET  = 8'h7F;

  // layout of the command word, msb first
  typedef struct packed {
    logic       globalSelectBit;
    logic [3:0] identifierField;
    logic [1:0] registerPointerField;
    logic       readSel;
  } cmd_t;

  // one received word event
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
  } rx_word_t;
endpackage
`default_nettype wire

/* File: src/word_fifo.sv */
// flip-flop fifo between the command decoder and the serial transmitter
`default_nettype none
module word_fifo
  import chain_link_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // filling side
  input  wire logic             inValid,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  inReady,
  // draining side
  output logic                  outValid,
  output logic      [WIDTH-1:0] outData,
  input  wire logic             outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wrPtr;
  logic [AW-1:0]    rdPtr;
  logic [AW:0]      count;
  logic             push;
  logic             pop;

  assign inReady  = (count != (AW+1)'(DEPTH));
  assign outValid = (count != '0);
  assign outData  = mem[rdPtr];
  assign push     = inValid & inReady;
  assign pop      = outValid & outReady;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wrPtr] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wrPtr <= '0;
      rdPtr <= '0;
      count <= '0;
    end else begin
      if (push) begin
        wrPtr <= (wrPtr == AW'(DEPTH - 1)) ? '0 : wrPtr + 1'b1;
      end
      if (pop) begin
        rdPtr <= (rdPtr == AW'(DEPTH - 1)) ? '0 : rdPtr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

/* File: src/serial_word_tx.sv */
// framed serial transmitter at a measured bit period
`default_nettype none
module serial_word_tx
  import chain_link_pkg::*;
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                sys_rst,
  // bit period in clock cycles
  input  wire logic [PERIOD_W-1:0] bitPeriod,
  // word to send
  input  wire logic                inValid,
  input  wire logic [7:0]          inData,
  output logic                     inReady,
  // line side
  output logic                     txLine,
  output logic                     busy,
  output logic                     wordDone
);
  logic [FRAME_BITS-1:0] shiftReg;
  logic [3:0]            bitsLeft;
  logic [PERIOD_W-1:0]   divCnt;
  logic                  bitTick;

  assign inReady = ~busy;
  assign bitTick = busy & (divCnt == '0);

  // bit-rate enable from a divider reloaded with the measured period
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      divCnt <= '0;
    end else if (inValid & inReady) begin
      divCnt <= bitPeriod - 1'b1;
    end else if (busy) begin
      divCnt <= bitTick ? bitPeriod - 1'b1 : divCnt - 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      shiftReg <= '1;
      bitsLeft <= '0;
      busy     <= 1'b0;
      txLine   <= 1'b1;
      wordDone <= 1'b0;
    end else begin
      wordDone <= 1'b0;
      if (inValid & inReady) begin
        // stop high, eight data bits lsb first, start low
        shiftReg <= {1'b1, inData, 1'b0};
        bitsLeft <= 4'(FRAME_BITS);
        busy     <= 1'b1;
        txLine   <= 1'b0;
      end else if (bitTick) begin
        if (bitsLeft == 4'h1) begin
          busy     <= 1'b0;
          wordDone <= 1'b1;
          txLine   <= 1'b1;
        end else begin
          txLine <= shiftReg[1];
        end
        shiftReg <= {1'b1, shiftReg[FRAME_BITS-1:1]};
        bitsLeft <= bitsLeft - 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

/* File: src/daisy_chain_sensor_link.sv */
// auto-baud daisy-chain serial interface engine of the sensor
//
// Contract
// - no byte for 28 ms inside a transaction resets interface, awaits calibration.
// - every byte moved on the link restarts the inactivity timer.
// - each word carries eight data bits, least significant first.
// - each word has a low start bit and a high stop bit.
// - transactions open with calibration word 55h, measured to lock the bit rate.
// - calibration, then command, then data from host on writes, device on reads.
// - input is forwarded to output except while sending or assigning addresses.
// - command top bit 0 means individual, 1 means global.
// - after power-up the path is pass-through.
// - init command makes every device break its pass-through path.
// - assign word 1001_0000 follows; first device stores low nibble as identifier.
// - device sends assign word with identifier plus one, then reconnects.
// - at most 16 devices, matching the four-bit identifier.
// - command 11110 pp r is global access, pointer in bits 2..1, read in bit 0.
// - global write: one data word follows, every device loads it.
// - global read: devices answer in identifier order, each breaking then reconnecting.
// - pointer 00 temperature read-only, 01 config, 10 low limit, 11 high limit.
// - individual command: bit 7 zero, id in bits 6..3, pointer 2..1, read bit 0.
// - individual read or write is served only by the device with matching id.
`default_nettype none
module daisy_chain_sensor_link
  import chain_link_pkg::*;
#(
  parameter int TimeoutCycles = TIMEOUT_CYCLES
) (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       sys_rst,
  // serial chain
  input  wire logic       rxIn,
  output logic            txOut,
  // sensor core side
  input  wire logic [7:0] tempValue,
  output logic      [7:0] configReg,
  output logic      [7:0] lowLimit,
  output logic      [7:0] highLimit,
  output logic      [3:0] deviceId,
  output logic            idValid,
  output logic            pathBroken
);
  typedef enum {RX_CAL_WAIT, RX_CAL_MEAS, RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
  typedef enum {P_CMD, P_ASSIGN, P_PUSH_CAL, P_PUSH_ID, P_WDATA, P_WSKIP, P_RWAIT, P_SEND, P_DRAIN} proto_state_t;

  rx_state_t           rxState;
  proto_state_t        protoState;
  logic                rxPrev;
  logic                rxFall;
  logic [MEAS_W-1:0]   measCnt;
  logic [2:0]          fallCnt;
  logic [PERIOD_W-1:0] bitPeriod;
  logic [PERIOD_W-1:0] sampleCnt;
  logic [2:0]          bitIdx;
  logic [7:0]          shiftIn;
  rx_word_t            rxWord;
  cmd_t                cmd;
  logic [1:0]          ptrHeld;
  logic [3:0]          turnCnt;
  logic [TIMEOUT_W-1:0] idleCnt;
  logic                timeoutHit;
  logic                endTxn;
  logic                inTxn;
  logic                fifoInValid;
  logic [7:0]          fifoInData;
  logic                fifoInReady;
  logic                fifoOutValid;
  logic [7:0]          fifoOutData;
  logic                txReady;
  logic                txLine;
  logic                txBusy;
  logic                txDone;
  logic [7:0]          selData;

  assign rxFall     = rxPrev & ~rxIn;
  assign cmd        = cmd_t'(rxWord.data);
  assign inTxn      = (rxState != RX_CAL_WAIT);
  assign timeoutHit = inTxn & (idleCnt == TIMEOUT_W'(TimeoutCycles - 1));

  // forward the input straight through unless this device owns the output
  assign txOut = pathBroken ? txLine : rxIn;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxPrev <= 1'b1;
    end else begin
      rxPrev <= rxIn;
    end
  end

  // inactivity timer, restarted by every word received or sent
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      idleCnt <= '0;
    end else if (!inTxn || rxWord.valid || txDone || timeoutHit) begin
      idleCnt <= '0;
    end else begin
      idleCnt <= idleCnt + 1'b1;
    end
  end

  // receiver: calibration measurement, then mid-bit sampling of framed words
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rxState   <= RX_CAL_WAIT;
      measCnt   <= '0;
      fallCnt   <= '0;
      bitPeriod <= '1;
      sampleCnt <= '0;
      bitIdx    <= '0;
      shiftIn   <= '0;
      rxWord    <= '0;
    end else begin
      rxWord.valid <= 1'b0;
      if (timeoutHit || endTxn) begin
        rxState <= RX_CAL_WAIT;
      end else begin
        unique case (rxState)
          RX_CAL_WAIT: begin
            if (rxFall) begin
              measCnt <= MEAS_W'(1); // the detecting cycle counts too, so eight bits give the full period
              fallCnt <= '0;
              rxState <= RX_CAL_MEAS;
            end
          end
          RX_CAL_MEAS: begin
            // 55h has a falling edge every second bit: four more falls span eight bits
            measCnt <= measCnt + 1'b1;
            if (rxFall) begin
              if (fallCnt == 3'(CAL_FALL_EDGES - 1)) begin
                bitPeriod    <= measCnt[PERIOD_W+2:3];
                rxWord.valid <= 1'b1;
                rxWord.data  <= CAL_WORD;
                rxState      <= RX_IDLE;
              end
              fallCnt <= fallCnt + 1'b1;
            end
          end
          RX_IDLE: begin
            if (rxFall) begin
              sampleCnt <= {1'b0, bitPeriod[PERIOD_W-1:1]};
              rxState   <= RX_START;
            end
          end
          RX_START: begin
            // recheck the start bit at its middle to reject glitches
            if (sampleCnt == '0) begin
              sampleCnt <= bitPeriod - 1'b1;
              bitIdx    <= '0;
              rxState   <= rxIn ? RX_IDLE : RX_DATA;
            end else begin
              sampleCnt <= sampleCnt - 1'b1;
            end
          end
          RX_DATA: begin
            if (sampleCnt == '0) begin
              shiftIn   <= {rxIn, shiftIn[7:1]};
              sampleCnt <= bitPeriod - 1'b1;
              bitIdx    <= bitIdx + 1'b1;
              if (bitIdx == 3'(WORD_BITS - 1)) begin
                rxState <= RX_STOP;
              end
            end else begin
              sampleCnt <= sampleCnt - 1'b1;
            end
          end
          RX_STOP: begin
            if (sampleCnt == '0) begin
              // a low stop bit is a framing error and the word is dropped
              rxWord.valid <= rxIn;
              rxWord.data  <= shiftIn;
              rxState      <= RX_IDLE;
            end else begin
              sampleCnt <= sampleCnt - 1'b1;
            end
          end
        endcase
      end
    end
  end

  // register selected by the pointer; temperature comes from the core
  always_comb begin
    unique case (ptrHeld)
      PTR_TEMP:   selData = tempValue;
      PTR_CONFIG: selData = configReg;
      PTR_TLOW:   selData = lowLimit;
      PTR_THIGH:  selData = highLimit;
    endcase
  end

  // words queued for the transmitter
  always_comb begin
    fifoInValid = 1'b0;
    fifoInData  = selData;
    unique case (protoState)
      P_PUSH_CAL: begin
        fifoInValid = 1'b1;
        fifoInData  = CAL_WORD;
      end
      P_PUSH_ID: begin
        fifoInValid = 1'b1;
        fifoInData  = {ASSIGN_PREFIX, 4'(deviceId + 1'b1)};
      end
      P_SEND: begin
        fifoInValid = 1'b1;
      end
      default: begin
        fifoInValid = 1'b0;
      end
    endcase
  end

  // command decoder; a full fifo simply holds the push states
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      protoState <= P_CMD;
      ptrHeld    <= PTR_TEMP;
      turnCnt    <= '0;
      endTxn     <= 1'b0;
    end else begin
      endTxn <= 1'b0;
      if (timeoutHit) begin
        protoState <= P_CMD;
      end else if (!inTxn && protoState != P_DRAIN) begin
        protoState <= P_CMD;
      end else begin
        unique case (protoState)
          P_CMD: begin
            if (rxWord.valid && rxWord.data != CAL_WORD) begin
              ptrHeld <= cmd.registerPointerField;
              if (rxWord.data == INIT_CMD) begin
                protoState <= P_ASSIGN;
              end else if (cmd.globalSelectBit) begin
                if (rxWord.data[7:3] == GLOBAL_RW_PREF) begin
                  if (!cmd.readSel) begin
                    protoState <= P_WDATA;
                  end else if (idValid) begin
                    turnCnt    <= deviceId;
                    protoState <= P_RWAIT;
                  end else begin
                    endTxn <= 1'b1;
                  end
                end else begin
                  endTxn <= 1'b1;
                end
              end else if (idValid && cmd.identifierField == deviceId) begin
                protoState <= cmd.readSel ? P_SEND : P_WDATA;
              end else if (!cmd.readSel) begin
                protoState <= P_WSKIP; // another device's write still brings its data word
              end else begin
                endTxn <= 1'b1;
              end
            end
          end
          P_ASSIGN: begin
            if (rxWord.valid && rxWord.data[7:4] == ASSIGN_PREFIX) begin
              protoState <= P_PUSH_CAL;
            end
          end
          P_PUSH_CAL: begin
            // next device needs its own calibration word before the assign word
            if (fifoInReady) begin
              protoState <= P_PUSH_ID;
            end
          end
          P_PUSH_ID: begin
            if (fifoInReady) begin
              protoState <= P_DRAIN;
            end
          end
          P_WDATA, P_WSKIP: begin
            if (rxWord.valid) begin
              endTxn     <= 1'b1;
              protoState <= P_CMD;
            end
          end
          P_RWAIT: begin
            // let the answers of lower identifiers pass first
            if (turnCnt == '0) begin
              protoState <= P_SEND;
            end else if (rxWord.valid) begin
              turnCnt <= turnCnt - 1'b1;
            end
          end
          P_SEND: begin
            if (fifoInReady) begin
              protoState <= P_DRAIN;
            end
          end
          P_DRAIN: begin
            if (!fifoOutValid && !txBusy) begin
              endTxn     <= 1'b1;
              protoState <= P_CMD;
            end
          end
        endcase
      end
    end
  end

  // path break: held from init or a read turn until own words are out
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pathBroken <= 1'b0;
    end else if (timeoutHit) begin
      pathBroken <= 1'b0;
    end else if (protoState == P_CMD && rxWord.valid && rxWord.data == INIT_CMD) begin
      pathBroken <= 1'b1;
    end else if (protoState == P_RWAIT && turnCnt == '0) begin
      pathBroken <= 1'b1;
    end else if (protoState == P_CMD && rxWord.valid && idValid && !cmd.globalSelectBit
                 && cmd.readSel && cmd.identifierField == deviceId && rxWord.data != CAL_WORD) begin
      pathBroken <= 1'b1;
    end else if (protoState == P_DRAIN && !fifoOutValid && !txBusy) begin
      pathBroken <= 1'b0;
    end
  end

  // identifier store
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      deviceId <= '0;
      idValid  <= 1'b0;
    end else if (protoState == P_ASSIGN && rxWord.valid && rxWord.data[7:4] == ASSIGN_PREFIX) begin
      deviceId <= rxWord.data[3:0];
      idValid  <= 1'b1;
    end
  end

  // register writes; the temperature pointer is read-only and ignores writes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      configReg <= CONFIG_RESET;
      lowLimit  <= TLOW_RESET;
      highLimit <= THIGH_RESET;
    end else if (protoState == P_WDATA && rxWord.valid && !timeoutHit) begin
      unique case (ptrHeld)
        PTR_CONFIG: configReg <= rxWord.data;
        PTR_TLOW:   lowLimit  <= rxWord.data;
        PTR_THIGH:  highLimit <= rxWord.data;
        PTR_TEMP:   configReg <= configReg;
      endcase
    end
  end

  word_fifo #(
    .WIDTH (WORD_BITS),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .inValid  (fifoInValid),
    .inData   (fifoInData),
    .inReady  (fifoInReady),
    .outValid (fifoOutValid),
    .outData  (fifoOutData),
    .outReady (txReady)
  );

  serial_word_tx u_tx (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .bitPeriod (bitPeriod),
    .inValid   (fifoOutValid),
    .inData    (fifoOutData),
    .inReady   (txReady),
    .txLine    (txLine),
    .busy      (txBusy),
    .wordDone  (txDone)
  );
endmodule
`default_nettype wire

/* File: bench/link_props.sv */
// concurrent checks on the ports of the sensor link
`default_nettype none
module link_props
  import chain_link_pkg::*;
#(
  parameter int TimeoutCycles = TIMEOUT_CYCLES
) (
  // clock and reset
  input wire logic       clk,
  input wire logic       sys_rst,
  // chain and core side
  input wire logic       rxIn,
  input wire logic       txOut,
  input wire logic [7:0] tempValue,
  input wire logic [7:0] configReg,
  input wire logic [7:0] lowLimit,
  input wire logic [7:0] highLimit,
  input wire logic [3:0] deviceId,
  input wire logic       idValid,
  input wire logic       pathBroken
);
  timeunit 1ns;
  timeprecision 1ps;
  // slack covers the tail of the last word before the timer restarts
  localparam int SlackCycles = 32768;
  logic prevRx;
  logic prevTx;
  int   quietCnt;
  always_ff @(posedge clk) begin
    prevRx <= rxIn;
    prevTx <= txOut;
    if (sys_rst || !pathBroken || rxIn != prevRx || txOut != prevTx) begin
      quietCnt <= 0;
    end else begin
      quietCnt <= quietCnt + 1;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  pass_through_a: assert property (!pathBroken |-> txOut == rxIn)
    else $error("txOut differs from rxIn in pass-through");
  reset_value_a: assert property ($past(sys_rst) |-> !pathBroken && !idValid && configReg == CONFIG_RESET
    && lowLimit == TLOW_RESET && highLimit == THIGH_RESET) else $error("wrong state after reset");
  id_change_a: assert property ($changed(deviceId) |-> pathBroken && idValid)
    else $error("identifier changed outside assignment");
  id_rise_a: assert property ($rose(idValid) |-> pathBroken)
    else $error("identifier taken without a broken path");
  write_path_a: assert property ($changed({configReg, lowLimit, highLimit}) |-> !pathBroken)
    else $error("register written while the path is broken");
  quiet_bound_a: assert property (quietCnt <= TimeoutCycles + SlackCycles)
    else $error("path held broken past the inactivity limit");
  reconnect_high_a: assert property ($fell(pathBroken) |-> $past(txOut))
    else $error("path restored while the line was low");
  // assumes a bit period above eight cycles
  start_width_a: assert property (pathBroken && $past(pathBroken) && $fell(txOut) |=> !txOut [*8])
    else $error("low bit on the sent frame too short");
  cover property ($rose(pathBroken));
  cover property ($rose(idValid));
  cover property ($changed(configReg));
endmodule
bind daisy_chain_sensor_link link_props #(.TimeoutCycles(TimeoutCycles)) props (
  .clk(clk), .sys_rst(sys_rst), .rxIn(rxIn), .txOut(txOut), .tempValue(tempValue),
  .configReg(configReg), .lowLimit(lowLimit), .highLimit(highLimit),
  .deviceId(deviceId), .idValid(idValid), .pathBroken(pathBroken)
);
`default_nettype wire

/* File: bench/host_serial_model.sv */
// behavioural host serial controller at both ends of the chain
`default_nettype none
module host_serial_model
  import chain_link_pkg::*;
(
  // clock
  input  wire logic       clk,
  // chain ends
  input  wire logic       lineIn,
  output var  logic       lineOut,
  // returned word event
  output var  logic       recvValid,
  output var  logic [7:0] recvData,
  output var  logic       recvStop
);
  timeunit 1ns;
  timeprecision 1ps;
  int         period = 48; // one rate kept for a whole transaction
  logic       busyRx = 1'b0;
  int         cnt    = 0;
  int         bitIdx = 0;
  logic [7:0] shift  = 8'h00;
  initial lineOut = 1'b1;
  // call just after a rising edge; push-pull line idles high
  task automatic send_word(input logic [7:0] w);
    logic [9:0] f;
    f = {1'b1, w, 1'b0}; // low start, lsb first, high stop
    for (int i = 0; i < FRAME_BITS; i++) begin
      lineOut <= f[i];
      repeat (period) @(posedge clk);
    end
  endtask
  // mid-bit sampler of the chain's output
  always @(posedge clk) begin
    recvValid <= 1'b0;
    if (!busyRx) begin
      busyRx <= (lineIn === 1'b0);
      cnt    <= period / 2;
      bitIdx <= 0;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end else begin
      cnt    <= period;
      bitIdx <= bitIdx + 1;
      if (bitIdx == 0) begin
        busyRx <= (lineIn === 1'b0);
      end else if (bitIdx < 9) begin
        shift <= {lineIn, shift[7:1]};
      end else begin
        busyRx    <= 1'b0;
        recvValid <= 1'b1;
        recvData  <= shift;
        recvStop  <= lineIn;
      end
    end
  end
endmodule
`default_nettype wire

/* File: bench/daisy_chain_sensor_link_bench.sv */
// self-checking bench of the daisy-chain sensor link
`default_nettype none
`define CHK(got, want) begin cmp_count++; if ((got) !== (want)) begin num_errors++; \
  $display("[FAIL] %0t got %h expected %h", $time, got, want); end end
module daisy_chain_sensor_link_bench
  import chain_link_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int ToCycles = 6000;
  logic       clk        = 1'b0;
  logic       sys_rst    = 1'b1;
  logic [7:0] tempValue  = 8'h00;
  logic       rxIn;
  logic       txOut;
  logic [7:0] configReg;
  logic [7:0] lowLimit;
  logic [7:0] highLimit;
  logic [3:0] deviceId;
  logic       idValid;
  logic       pathBroken;
  logic       recvValid;
  logic [7:0] recvData;
  logic       recvStop;
  logic [7:0] expq[$];
  logic [7:0] expReg[4];
  logic [7:0] d;
  logic [7:0] head;
  int         seed       = 42480;
  int         cycles     = 0;
  int         num_errors = 0;
  int         cmp_count  = 0;
  always #10 clk = ~clk;
  daisy_chain_sensor_link #(.TimeoutCycles(ToCycles)) dut (.clk(clk), .sys_rst(sys_rst), .rxIn(rxIn),
    .txOut(txOut), .tempValue(tempValue), .configReg(configReg), .lowLimit(lowLimit),
    .highLimit(highLimit), .deviceId(deviceId), .idValid(idValid), .pathBroken(pathBroken));
  host_serial_model host (.clk(clk), .lineIn(txOut), .lineOut(rxIn), .recvValid(recvValid),
    .recvData(recvData), .recvStop(recvStop));
  task automatic report_and_stop();
    $display("errors %0d comparisons %0d", num_errors, cmp_count);
    if (num_errors == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // oldest note against each word that comes back
  always @(posedge clk) begin
    if (recvValid === 1'b1) begin
      `CHK(expq.size() > 0, 1'b1)
      head = (expq.size() > 0) ? expq.pop_front() : 8'h00;
      `CHK(recvData, head)
      `CHK(recvStop, 1'b1)
    end
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 90000) begin
      num_errors++;
      report_and_stop();
    end
  end
  function automatic logic [7:0] regOf(input int p);
    return (p == 1) ? configReg : (p == 2) ? lowLimit : highLimit;
  endfunction
  task automatic send(input logic [7:0] w, input logic echo);
    if (echo) expq.push_back(w);
    host.send_word(w);
  endtask
  // waits for every noted word and for the path to come back
  task automatic drain();
    int n;
    n = 0;
    while ((expq.size() != 0 || pathBroken !== 1'b0) && n < 20000) begin
      @(posedge clk);
      n++;
    end
    `CHK(expq.size(), 0)
    repeat (3 * host.period) @(posedge clk);
  endtask
  task automatic txn(input logic [7:0] c, input logic [7:0] w);
    send(CAL_WORD, 1'b1);
    send(c, 1'b1);
    send(w, 1'b1);
    drain();
  endtask
  task automatic rd(input logic [7:0] c, input logic [7:0] want, input int up);
    send(CAL_WORD, 1'b1);
    send(c, 1'b1);
    repeat (up) send(8'($random(seed)), 1'b1); // earlier devices answer first
    expq.push_back(want);
    drain();
  endtask
  task automatic assign_ids(input logic [3:0] id);
    send(CAL_WORD, 1'b1);
    send(INIT_CMD, 1'b1);
    `CHK(pathBroken, 1'b1)
    send({ASSIGN_PREFIX, id}, 1'b0);
    expq.push_back(CAL_WORD);
    expq.push_back({ASSIGN_PREFIX, id + 4'h1}); // 15 wraps to 0
    drain();
    `CHK(deviceId, id)
    `CHK(idValid, 1'b1)
  endtask
  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge clk);
    `CHK({pathBroken, idValid}, 2'b00)
    `CHK({configReg, lowLimit, highLimit}, {CONFIG_RESET, TLOW_RESET, THIGH_RESET})
    assign_ids(4'hF);
    host.period = 40; // a new rate for later transactions
    assign_ids(4'h2);
    for (int p = 1; p < 4; p++) begin
      d = 8'($random(seed));
      txn({1'b0, 4'h2, 2'(p), 1'b0}, d);
      `CHK(regOf(p), d)
      txn({1'b0, 4'h5, 2'(p), 1'b0}, ~d);
      `CHK(regOf(p), d)
      expReg[p] = d ^ 8'h5A;
      txn({GLOBAL_RW_PREF, 2'(p), 1'b0}, expReg[p]);
      `CHK(regOf(p), expReg[p])
    end
    txn({1'b0, 4'h2, PTR_TEMP, 1'b0}, 8'hC3);
    txn({GLOBAL_RW_PREF, PTR_TEMP, 1'b0}, 8'h3C);
    `CHK({configReg, lowLimit, highLimit}, {expReg[1], expReg[2], expReg[3]})
    for (int p = 0; p < 4; p++) begin
      tempValue <= 8'($random(seed));
      @(posedge clk);
      expReg[0] = tempValue;
      rd({1'b0, 4'h2, 2'(p), 1'b1}, expReg[p], 0);
      rd({GLOBAL_RW_PREF, 2'(p), 1'b1}, expReg[p], 2);
    end
    send(CAL_WORD, 1'b1);
    send(INIT_CMD, 1'b1);
    repeat (ToCycles + 1000) @(posedge clk);
    `CHK(pathBroken, 1'b0)
    send(CAL_WORD, 1'b1);
    repeat (ToCycles - 1000) @(posedge clk); // gap kept short of the limit
    send({1'b0, 4'h2, PTR_CONFIG, 1'b0}, 1'b1);
    repeat (ToCycles - 1000) @(posedge clk);
    send(8'hA5, 1'b1);
    `CHK(configReg, 8'hA5)
    drain();
    report_and_stop();
  end
endmodule
`default_nettype wire
